// ### hw/fll_config_top.sv
`timescale 1ns/1ps
`include "fll_map.svh"
// Functional notes
// - Keep third PLL fraction low byte separately.
// - Reference source: master, bit, oscillator, reserved.
// - Fractional bit selects integer or fractional mode.
// - Loop enable and free-run oscillator enable.
// - Output clock is vco divided by code+1.
// - Predivide reference by one, two or four.
// - Vco ratio code multiplies by 1..16.
// - Forced select drives oscillator from forced value.
// - Any forced value accepted; reset gives 011001.
// - Numerator of fraction, used in fractional mode.
// - Denominator divides numerator to form fraction.
// - Ten-bit integer multiplier, reset value eight.
// - Pll input select: oscillator 0, master 1.
module fll_config_top #(
  parameter int DIV_W = 7,  // Width of the divide ratios.
  parameter int CNT_W = 16  // Width of the vco tick counter.
) (
  input  logic              clk,              // 100 MHz system clock.
  input  logic              rst,              // Synchronous reset, active high.
  input  logic [7:0]        reg_addr,         // Register offset.
  input  fll_pkg::fll_word_t reg_wdata,       // Write data.
  input  logic              reg_write,        // Write strobe, one cycle.
  input  logic              reg_read,         // Read strobe, one cycle.
  output fll_pkg::fll_word_t reg_rdata,       // Read data, registered.
  output logic              reg_rvalid,       // Read data valid pulse.
  input  logic              master_clock_in,  // Master clock pin.
  input  logic              bit_clock_in,     // Bit clock pin.
  input  logic              int_osc_in,       // Internal oscillator clock.
  input  logic              vco_clock,        // Loop oscillator clock.
  output logic              ref_tick,         // Divided reference pulse.
  output logic              loop_output_clock,// Divided vco pulse.
  output logic [5:0]        osc_code,         // Oscillator control code.
  output logic              osc_power,        // Oscillator powered.
  output logic [14:0]       vco_target,       // Vco ticks per ref period.
  output logic [7:0]        third_pll_fraction,// Third PLL fraction low byte.
  output logic              seq_enable,       // Sequencer enable.
  output logic              pll_input_select, // PLL input clock select.
  output logic              seq_conflict      // Sequencer on with master.
);
  import fll_pkg::*;

  // All state of the block, registers first.
  typedef struct packed {
    fll_word_t        pll3_frac;  // Third PLL fraction low byte.
    fll_word_t        pll_src;    // PLL clock source register.
    fll_word_t        seq;        // Sequencer control.
    fll_word_t        src;        // Loop control and source.
    fll_word_t        div;        // Output and reference dividers.
    fll_word_t        vco;        // Vco ratio.
    fll_word_t        frc;        // Forced oscillator.
    fll_word_t        num;        // Fraction numerator.
    fll_word_t        den;        // Fraction denominator.
    fll_word_t        nmul;       // Integer multiplier.
    fll_word_t        rdata;      // Read data.
    logic             rvalid;     // Read answer pulse.
    logic             ref_lvl;    // Last selected reference level.
    logic             vco_lvl;    // Last vco level.
    logic [15:0]      acc;        // Fraction accumulator.
    logic [CNT_W-1:0] vcnt;       // Vco ticks in this period.
    logic [14:0]      target;     // Expected vco ticks per period.
    logic [5:0]       code;       // Oscillator control code.
  } fll_state_t;

  fll_state_t st;
  fll_state_t next_st;

  logic [3:0]       pin_lvl;      // Synchronised pin levels.
  logic             ref_sel;      // Level of selected reference.
  logic             ref_edge;     // Rising edge of reference.
  logic             vco_edge;     // Rising edge of vco.
  logic             div_ref;      // Predivided reference pulse.
  logic [DIV_W-1:0] pre_ratio;    // Predivide ratio.
  logic [DIV_W-1:0] out_ratio;    // Output divide ratio.
  logic             loop_en;      // Loop enable bit.
  logic             frac_en;      // Fractional mode bit.
  logic             force_sel;    // Forced oscillator select.
  fll_ref_t         src_code;     // Reference source field.
  logic [16:0]      frac_sum;     // Accumulator plus numerator.
  logic             carry;        // Fractional carry this period.
  logic [10:0]      nsum;         // Integer part plus carry.

  // Shift amount for the vco ratio code; any 1XX code means sixteen.
  function automatic logic [2:0] vco_shift(input logic [2:0] c);
    logic [2:0] s;
    s = 3'h4;
    if (!c[2]) begin
      s = {1'b0, c[1:0]};
    end
    return s;
  endfunction

  // Register read mux; unmapped offsets read as zero.
  function automatic fll_word_t read_word(input fll_state_t s, input logic [7:0] a);
    fll_word_t w;
    w = 16'h0000;
    unique case (a)
      `FLL_OFS_PLL3_FRAC: w = s.pll3_frac;
      `FLL_OFS_PLL_SRC:   w = s.pll_src;
      `FLL_OFS_SEQ:       w = s.seq;
      `FLL_OFS_SRC:       w = s.src;
      `FLL_OFS_DIV:       w = s.div;
      `FLL_OFS_VCO:       w = s.vco;
      `FLL_OFS_FRC:       w = s.frc;
      `FLL_OFS_NUM:       w = s.num;
      `FLL_OFS_DEN:       w = s.den;
      `FLL_OFS_NMUL:      w = s.nmul;
      `FLL_OFS_STATUS:    w = {13'h0000, seq_conflict, loop_en & ~force_sel, src_code == FLL_REF_RSVD};
      default:            w = 16'h0000;
    endcase
    return w;
  endfunction

  // Clock pins cross into the system domain; sampling limits usable
  // reference and vco rates to well under half of 100 MHz.
  fll_sync #(
    .W(4)
  ) u_sync (
    .clk    (clk),
    .rst    (rst),
    .pin_in ({vco_clock, int_osc_in, bit_clock_in, master_clock_in}),
    .level  (pin_lvl)
  );

  // Field decode from the stored registers.
  always_comb begin
    loop_en   = st.src[`FLL_BIT_LOOP_EN];
    frac_en   = st.src[`FLL_BIT_FRAC_EN];
    force_sel = st.frc[`FLL_BIT_FORCE];
    src_code  = fll_ref_t'(st.src[`FLL_POS_SRC +: 2]);
  end

  // Reference selection; the reserved code leaves the loop without reference.
  always_comb begin
    unique case (src_code)
      FLL_REF_MASTER: ref_sel = pin_lvl[0];
      FLL_REF_BIT:    ref_sel = pin_lvl[1];
      FLL_REF_OSC:    ref_sel = pin_lvl[2];
      FLL_REF_RSVD:   ref_sel = 1'b0;
    endcase
    ref_edge = ref_sel & ~st.ref_lvl;
    vco_edge = pin_lvl[3] & ~st.vco_lvl;
  end

  // Divide ratios; a reserved predivide code stops the reference.
  always_comb begin
    unique case (st.div[1:0])
      2'h0:    pre_ratio = DIV_W'(1);
      2'h1:    pre_ratio = DIV_W'(2);
      2'h2:    pre_ratio = DIV_W'(4);
      default: pre_ratio = DIV_W'(0);
    endcase
    out_ratio = DIV_W'({1'b0, st.div[`FLL_POS_OUTDIV +: 6]} + 7'h01);
  end

  // Reference predivider.
  fll_div #(
    .W(DIV_W)
  ) u_prediv (
    .clk      (clk),
    .rst      (rst),
    .tick_in  (ref_edge),
    .ratio    (pre_ratio),
    .tick_out (div_ref)
  );

  // Output divider from the vco.
  fll_div #(
    .W(DIV_W)
  ) u_outdiv (
    .clk      (clk),
    .rst      (rst),
    .tick_in  (vco_edge),
    .ratio    (out_ratio),
    .tick_out (loop_output_clock)
  );

  // Fractional accumulator: the numerator is added once per reference
  // period and the denominator is taken off on overflow, so on average the
  // multiplier gains numerator over denominator without a divider.
  always_comb begin
    frac_sum = {1'b0, st.acc} + {1'b0, st.num};
    // A zero denominator never yields a carry rather than running away.
    carry = frac_en && (st.den != 16'h0000) && (frac_sum >= {1'b0, st.den});
    nsum  = {1'b0, st.nmul[9:0]} + {10'h000, carry};
  end

  // Next-state logic for registers, read port and loop.
  always_comb begin
    next_st        = st;
    next_st.rvalid = 1'b0;
    next_st.ref_lvl = ref_sel;
    next_st.vco_lvl = pin_lvl[3];

    // Writes store implemented bits; reserved bits keep what was written.
    if (reg_write) begin
      unique case (reg_addr)
        `FLL_OFS_PLL3_FRAC: next_st.pll3_frac = reg_wdata & `FLL_MSK_PLL3_FRAC;
        `FLL_OFS_PLL_SRC:   next_st.pll_src = reg_wdata & `FLL_MSK_PLL_SRC;
        `FLL_OFS_SEQ:       next_st.seq = reg_wdata & `FLL_MSK_SEQ;
        `FLL_OFS_SRC:       next_st.src = reg_wdata & `FLL_MSK_SRC;
        `FLL_OFS_DIV:       next_st.div = reg_wdata & `FLL_MSK_DIV;
        `FLL_OFS_VCO:       next_st.vco = reg_wdata & `FLL_MSK_VCO;
        `FLL_OFS_FRC:       next_st.frc = reg_wdata & `FLL_MSK_FRC;
        `FLL_OFS_NUM:       next_st.num = reg_wdata;
        `FLL_OFS_DEN:       next_st.den = reg_wdata;
        `FLL_OFS_NMUL:      next_st.nmul = reg_wdata & `FLL_MSK_NMUL;
        default: begin
          // Unmapped and read-only offsets ignore writes.
        end
      endcase
    end

    // Read data returns the value before a same-cycle write.
    if (reg_read) begin
      next_st.rdata  = read_word(st, reg_addr);
      next_st.rvalid = 1'b1;
    end

    // Count vco edges within each reference period, saturating.
    if (div_ref) begin
      next_st.vcnt = CNT_W'(vco_edge);
    end else if (vco_edge && (st.vcnt != '1)) begin
      next_st.vcnt = CNT_W'(st.vcnt + 1'b1);
    end

    // Once per divided reference period the target is refreshed.
    if (div_ref) begin
      if (frac_en) begin
        next_st.acc = carry ? 16'(frac_sum - {1'b0, st.den}) : frac_sum[15:0];
      end else begin
        // Integer mode drops the fraction entirely.
        next_st.acc = 16'h0000;
      end
      next_st.target = 15'({4'h0, nsum} << vco_shift(st.vco[2:0]));
    end

    // Oscillator control: forced value wins over the loop.
    if (force_sel) begin
      next_st.code = st.frc[`FLL_POS_FRC_VAL +: 6];
    end else if (loop_en && div_ref) begin
      // Step the code one unit toward the expected tick count.
      if ((st.vcnt < {1'b0, st.target}) && (st.code != 6'h3F)) begin
        next_st.code = 6'(st.code + 1'b1);
      end else if ((st.vcnt > {1'b0, st.target}) && (st.code != 6'h00)) begin
        next_st.code = 6'(st.code - 1'b1);
      end
    end
  end

  // State register with documented reset values.
  always_ff @(posedge clk) begin
    if (rst) begin
      st           <= '0;
      st.pll3_frac <= `FLL_RST_PLL3_FRAC;
      st.pll_src   <= `FLL_RST_PLL_SRC;
      st.seq       <= `FLL_RST_SEQ;
      st.src       <= `FLL_RST_SRC;
      st.div       <= `FLL_RST_DIV;
      st.vco       <= `FLL_RST_VCO;
      st.frc       <= `FLL_RST_FRC;
      st.num       <= `FLL_RST_NUM;
      st.den       <= `FLL_RST_DEN;
      st.nmul      <= `FLL_RST_NMUL;
      st.code      <= 6'h19;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state.
  assign reg_rdata          = st.rdata;
  assign reg_rvalid         = st.rvalid;
  assign ref_tick           = div_ref;
  assign osc_code           = st.code;
  // The oscillator runs for the loop or for free running on its own.
  assign osc_power          = loop_en | st.src[`FLL_BIT_OSC_EN];
  assign vco_target         = st.target;
  assign third_pll_fraction = st.pll3_frac[7:0];
  assign seq_enable         = st.seq[`FLL_BIT_SEQ_EN];
  assign pll_input_select   = st.pll_src[`FLL_BIT_PLL_SEL];
  // Flags software that left the sequencer on with the master clock selected.
  assign seq_conflict       = seq_enable & pll_input_select;
endmodule

// ### inc/fll_map.svh
`ifndef FLL_MAP_SVH
`define FLL_MAP_SVH
// Register offsets on the control interface.
`define FLL_OFS_PLL3_FRAC  8'h8F
`define FLL_OFS_PLL_SRC    8'h83
`define FLL_OFS_SEQ        8'h96
`define FLL_OFS_SRC        8'h9B
`define FLL_OFS_DIV        8'h9C
`define FLL_OFS_VCO        8'h9D
`define FLL_OFS_FRC        8'h9F
`define FLL_OFS_NUM        8'hA0
`define FLL_OFS_DEN        8'hA1
`define FLL_OFS_NMUL       8'hA2
`define FLL_OFS_STATUS     8'hA3
// Reset values, reserved bits included.
`define FLL_RST_PLL3_FRAC  16'h0097
`define FLL_RST_PLL_SRC    16'h0010
`define FLL_RST_SEQ        16'h0003
`define FLL_RST_SRC        16'h000C
`define FLL_RST_DIV        16'h0039
`define FLL_RST_VCO        16'h0180
`define FLL_RST_FRC        16'h0032
`define FLL_RST_NUM        16'h0018
`define FLL_RST_DEN        16'h007D
`define FLL_RST_NMUL       16'h0008
// Implemented bits; all others read as zero.
`define FLL_MSK_PLL3_FRAC  16'h00FF
`define FLL_MSK_PLL_SRC    16'h0013
`define FLL_MSK_SEQ        16'h0003
`define FLL_MSK_SRC        16'h006F
`define FLL_MSK_DIV        16'h01FB
`define FLL_MSK_VCO        16'h0187
`define FLL_MSK_FRC        16'h007F
`define FLL_MSK_NMUL       16'h03FF
// Field positions.
`define FLL_BIT_PLL_SEL    1
`define FLL_BIT_SEQ_EN     1
`define FLL_BIT_LOOP_EN    0
`define FLL_BIT_OSC_EN     1
`define FLL_BIT_FRAC_EN    2
`define FLL_BIT_FORCE      0
`define FLL_POS_SRC        5
`define FLL_POS_OUTDIV     3
`define FLL_POS_FRC_VAL    1
`endif

// ### inc/fll_pkg.sv
package fll_pkg;
  // One register word of the control interface.
  typedef logic [15:0] fll_word_t;
  // Reference source codes in field order 00, 01, 10, 11.
  typedef enum logic [1:0] {
    FLL_REF_MASTER,
    FLL_REF_BIT,
    FLL_REF_OSC,
    FLL_REF_RSVD
  } fll_ref_t;
endpackage

// ### hw/fll_sync.sv
`timescale 1ns/1ps
module fll_sync #(
  parameter int W = 4  // Number of pins synchronised.
) (
  input  logic         clk,     // System clock.
  input  logic         rst,     // Synchronous reset, active high.
  input  logic [W-1:0] pin_in,  // Asynchronous pin levels.
  output logic [W-1:0] level    // Filtered level per pin.
);
  // Three stages and the accepted level.
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] stable;
  } fll_sync_t;

  fll_sync_t st;
  fll_sync_t next_st;

  // The first stage feeds only the second, so metastability never reaches logic.
  always_comb begin
    next_st    = st;
    next_st.s1 = pin_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < W; i++) begin
      // A change counts once the second and third stages agree.
      if (st.s2[i] == st.s3[i]) begin
        next_st.stable[i] = st.s3[i];
      end
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.stable;
endmodule

// ### hw/fll_div.sv
`timescale 1ns/1ps
module fll_div #(
  parameter int W = 7  // Width of the ratio and the count.
) (
  input  logic         clk,       // System clock.
  input  logic         rst,       // Synchronous reset, active high.
  input  logic         tick_in,   // One pulse per input period.
  input  logic [W-1:0] ratio,     // Divide ratio; zero stops the output.
  output logic         tick_out   // One pulse per ratio input pulses.
);
  // Count and registered output pulse.
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         out;
  } fll_div_t;

  fll_div_t st;
  fll_div_t next_st;

  // A ratio change takes effect at the next wrap or at once if below the count.
  always_comb begin
    next_st     = st;
    next_st.out = 1'b0;
    if (ratio == '0) begin
      // Stopped divider holds no stale phase.
      next_st.cnt = '0;
    end else if (tick_in) begin
      if (st.cnt >= W'(ratio - 1'b1)) begin
        next_st.cnt = '0;
        next_st.out = 1'b1;
      end else begin
        next_st.cnt = W'(st.cnt + 1'b1);
      end
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick_out = st.out;
endmodule

// ### verif/fll_config_top_properties.sv
`timescale 1ns/1ps
`include "fll_map.svh"
// Watches the register bus answer, the mirrored control outputs and the tick pulses.
module fll_config_top_properties (
  input logic               clk,                // System clock.
  input logic               rst,                // Synchronous reset, active high.
  input logic [7:0]         reg_addr,           // Register offset.
  input fll_pkg::fll_word_t reg_wdata,          // Write data.
  input logic               reg_write,          // Write strobe.
  input logic               reg_read,           // Read strobe.
  input logic               reg_rvalid,         // Read data valid.
  input logic               ref_tick,           // Divided reference pulse.
  input logic               loop_output_clock,  // Divided vco pulse.
  input logic [5:0]         osc_code,           // Oscillator control code.
  input logic               osc_power,          // Oscillator powered.
  input logic [14:0]        vco_target,         // Vco ticks per reference period.
  input logic [7:0]         third_pll_fraction, // Third PLL fraction low byte.
  input logic               seq_enable,         // Sequencer enable.
  input logic               pll_input_select,   // PLL input clock select.
  input logic               seq_conflict        // Sequencer on with master clock.
);
  // All checks run on the single system clock.
  default clocking cb @(posedge clk); endclocking

  a_read_answer: assert property (disable iff (rst) reg_read |=> reg_rvalid)
    else $error("read not answered one cycle later");
  a_rvalid_cause: assert property (disable iff (rst) reg_rvalid |-> $past(reg_read))
    else $error("read valid without a read");
  // The reset check has no disable, since it looks at the cycle just after a reset edge.
  a_reset_state: assert property (rst |=> seq_enable && osc_code == 6'h19 && vco_target == 15'h0000)
    else $error("outputs not at reset values");
  a_fraction_byte: assert property (disable iff (rst)
    (reg_write && reg_addr == `FLL_OFS_PLL3_FRAC) |=> third_pll_fraction == $past(reg_wdata[7:0]))
    else $error("fraction byte not updated");
  a_seq_mirror: assert property (disable iff (rst)
    (reg_write && reg_addr == `FLL_OFS_SEQ) |=> seq_enable == $past(reg_wdata[1]))
    else $error("sequencer enable not updated");
  a_select_mirror: assert property (disable iff (rst)
    (reg_write && reg_addr == `FLL_OFS_PLL_SRC) |=> pll_input_select == $past(reg_wdata[1]))
    else $error("input select not updated");
  a_power_write: assert property (disable iff (rst)
    (reg_write && reg_addr == `FLL_OFS_SRC) |=> osc_power == ($past(reg_wdata[0]) || $past(reg_wdata[1])))
    else $error("oscillator power wrong after write");
  a_conflict_tie: assert property (disable iff (rst) seq_conflict == (seq_enable && pll_input_select))
    else $error("conflict flag wrong");
  a_ref_single: assert property (disable iff (rst) ref_tick |=> !ref_tick)
    else $error("reference pulse longer than one cycle");
  a_out_single: assert property (disable iff (rst) loop_output_clock |=> !loop_output_clock)
    else $error("output pulse longer than one cycle");

  // Main scenarios seen at least once.
  c_conflict: cover property (disable iff (rst) seq_conflict);
  c_ref_tick: cover property (disable iff (rst) ref_tick);
  c_out_tick: cover property (disable iff (rst) loop_output_clock);
endmodule

bind fll_config_top fll_config_top_properties fll_config_top_properties_inst (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rvalid(reg_rvalid), .ref_tick(ref_tick), .loop_output_clock(loop_output_clock),
  .osc_code(osc_code), .osc_power(osc_power), .vco_target(vco_target), .third_pll_fraction(third_pll_fraction),
  .seq_enable(seq_enable), .pll_input_select(pll_input_select), .seq_conflict(seq_conflict)
);

// ### verif/fll_config_top_test.sv
`timescale 1ns/1ps
`include "fll_map.svh"
module fll_config_top_test;
  import fll_pkg::*;
  logic       clk = 1'b0;        // System clock.
  logic       rst = 1'b1;        // Synchronous reset.
  logic [7:0] reg_addr = 8'h00;  // Register offset.
  fll_word_t  reg_wdata = 16'h0; // Write data.
  logic       reg_write = 1'b0;  // Write strobe.
  logic       reg_read = 1'b0;   // Read strobe.
  logic [3:0] pin = 4'h0;        // Master, bit, oscillator and vco pins.
  fll_word_t  reg_rdata, d;      // Read data and a scratch word.
  logic [5:0] osc_code;          // Oscillator code.
  logic [14:0] vco_target;       // Vco target.
  logic [7:0] third_pll_fraction; // Fraction byte.
  logic       reg_rvalid, ref_tick, loop_output_clock, osc_power, seq_enable, pll_input_select, seq_conflict;
  int         checks, miscompares, n_ref, n_out, k, n, seed; // Counters and scratch.
  // Register table: offset, reset value, implemented bits, reserved bits kept at reset.
  logic [7:0] ofs [10] = '{`FLL_OFS_PLL3_FRAC, `FLL_OFS_PLL_SRC, `FLL_OFS_SEQ, `FLL_OFS_SRC, `FLL_OFS_DIV,
                           `FLL_OFS_VCO, `FLL_OFS_FRC, `FLL_OFS_NUM, `FLL_OFS_DEN, `FLL_OFS_NMUL};
  fll_word_t  rv [10] = '{`FLL_RST_PLL3_FRAC, `FLL_RST_PLL_SRC, `FLL_RST_SEQ, `FLL_RST_SRC, `FLL_RST_DIV,
                          `FLL_RST_VCO, `FLL_RST_FRC, `FLL_RST_NUM, `FLL_RST_DEN, `FLL_RST_NMUL};
  fll_word_t  msk [10] = '{`FLL_MSK_PLL3_FRAC, `FLL_MSK_PLL_SRC, `FLL_MSK_SEQ, `FLL_MSK_SRC, `FLL_MSK_DIV,
                           `FLL_MSK_VCO, `FLL_MSK_FRC, 16'hFFFF, 16'hFFFF, `FLL_MSK_NMUL};
  fll_word_t  rsv [10] = '{16'h0, 16'h0010, 16'h0001, 16'h0008, 16'h0, 16'h0180, 16'h0, 16'h0, 16'h0, 16'h0};

  fll_config_top fll_config_top_inst (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .master_clock_in(pin[0]),
    .bit_clock_in(pin[1]), .int_osc_in(pin[2]), .vco_clock(pin[3]), .ref_tick(ref_tick),
    .loop_output_clock(loop_output_clock), .osc_code(osc_code), .osc_power(osc_power),
    .vco_target(vco_target), .third_pll_fraction(third_pll_fraction), .seq_enable(seq_enable),
    .pll_input_select(pll_input_select), .seq_conflict(seq_conflict)
  );

  // 100 MHz clock.
  always #5 clk = ~clk;

  // Pulses are counted mid-cycle, where they are settled and stand once.
  always @(negedge clk) begin
    if (ref_tick === 1'b1) n_ref++;
    if (loop_output_clock === 1'b1) n_out++;
  end

  // Ratio code 1XX all mean sixteen.
  function automatic int ratio_shift(input int c);
    return (c > 3) ? 4 : c;
  endfunction

  task automatic finish_test();
    $display("Checks %0d, miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input fll_word_t seen, input fll_word_t exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // A write strobe stands one cycle; an idle edge follows so strobes never merge.
  task automatic wr(input logic [7:0] a, input fll_word_t v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    @(posedge clk);
  endtask

  // Read and compare; the answer is awaited under a bound.
  task automatic rc(input logic [7:0] a, input fll_word_t e);
    int i;
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    for (i = 0; i < 4 && reg_rvalid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 4) begin
      miscompares++;
      finish_test();
    end
    chk(reg_rdata, e);
    @(posedge clk);
  endtask

  // Rising edges on one pin, each level held four cycles so the synchroniser keeps up.
  // An eight-cycle period gives a 12.5 MHz reference, inside the predivided limit,
  // where ratio code 000 is the recommended setting.
  task automatic pulses(input int p, input int cnt);
    repeat (cnt) begin
      pin[p] <= 1'b1;
      repeat (4) @(posedge clk);
      pin[p] <= 1'b0;
      repeat (4) @(posedge clk);
    end
    repeat (8) @(posedge clk);
  endtask

  // A fresh reset clears divider phase left over from the previous case.
  task automatic restart();
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    n_ref = 0;
    n_out = 0;
  endtask

  initial begin
    seed = $urandom(32'h30A5);
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 10; i++) rc(ofs[i], rv[i]);
    chk({10'h0, osc_code}, 16'h0019);
    chk({14'h0, seq_enable, osc_power}, 16'h0002);
    // Random contents, reserved bits kept and denominator never zero.
    for (int i = 0; i < 10; i++) begin
      d = fll_word_t'($urandom);
      if (i == 8 && d == 16'h0) d = 16'h0001;
      d = (d & ~rsv[i]) | (rv[i] & rsv[i]);
      wr(ofs[i], d);
      if (i == 0) chk({8'h0, third_pll_fraction}, d & 16'h00FF);
      rc(ofs[i], d & msk[i]);
    end
    // Sequencer off first, then master clock, then the forbidden pairing.
    restart();
    wr(`FLL_OFS_SEQ, 16'h0001);
    wr(`FLL_OFS_PLL_SRC, 16'h0012);
    chk({14'h0, pll_input_select, seq_conflict}, 16'h0002);
    wr(`FLL_OFS_SEQ, 16'h0003);
    chk({15'h0, seq_conflict}, 16'h0001);
    // Status word shows the conflict with the loop off and a legal source.
    rc(`FLL_OFS_STATUS, 16'h0004);
    // Every source and predivider code, reserved ones included.
    for (int s = 0; s < 4; s++)
      for (int v = 0; v < 4; v++) begin
        restart();
        wr(`FLL_OFS_SRC, 16'h000C | 16'(s << 5));
        wr(`FLL_OFS_DIV, 16'h0038 | 16'(v));
        pulses((s == 3) ? 0 : s, 8);
        chk(16'(n_ref), (s == 3 || v == 3) ? 16'h0 : 16'(8 >> v));
      end
    // Output divider at its ends and at random codes.
    for (int j = 0; j < 5; j++) begin
      k = (j == 0) ? 0 : (j == 1) ? 63 : $urandom_range(62, 1);
      restart();
      wr(`FLL_OFS_DIV, 16'h0001 | 16'(k << 3));
      pulses(3, (k + 1) * 3);
      chk(16'(n_out), 16'h0003);
    end
    // Every ratio code, integer then fractional with a carry on every period.
    for (int c = 0; c < 8; c++) begin
      n = $urandom_range(1023, 1);
      restart();
      wr(`FLL_OFS_SRC, 16'h0008);
      wr(`FLL_OFS_NMUL, 16'(n));
      wr(`FLL_OFS_VCO, 16'h0180 | 16'(c));
      wr(`FLL_OFS_NUM, 16'h0005);
      wr(`FLL_OFS_DEN, 16'h0005);
      pulses(0, 4);
      chk({1'b0, vco_target}, 16'(n << ratio_shift(c)));
      wr(`FLL_OFS_SRC, 16'h000C);
      pulses(0, 4);
      chk({1'b0, vco_target}, 16'((n + 1) << ratio_shift(c)));
    end
    // Forced code, then the loop steps up from it with no vco edges.
    restart();
    k = $urandom_range(62, 0);
    wr(`FLL_OFS_FRC, 16'(k << 1) | 16'h0001);
    pulses(0, 4);
    chk({10'h0, osc_code}, 16'(k));
    wr(`FLL_OFS_FRC, 16'h0032);
    wr(`FLL_OFS_SRC, 16'h000D);
    pulses(0, 8);
    chk(16'(osc_code > 6'(k)), 16'h0001);
    wr(`FLL_OFS_SRC, 16'h000A);
    chk({15'h0, osc_power}, 16'h0001);
    finish_test();
  end
endmodule
